/* src/mrs_pkg.sv */
`default_nettype none
package mrs_pkg;
  // Clock and timing
  localparam int unsigned CLK_KHZ       = 20000;
  localparam int unsigned T_INT_TMO_MS  = 140;
  localparam int unsigned T_CAP_TMO_US  = 50;
  // Least times round up to whole cycles
  localparam int unsigned INT_TMO_CYC   = CLK_KHZ * T_INT_TMO_MS;
  localparam int unsigned CAP_TMO_CYC   = (CLK_KHZ * T_CAP_TMO_US + 999) / 1000;
  localparam int unsigned CNT_W         = 24;

  // Register bus
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 32;
  localparam logic [7:0]  OFF_STATUS    = 8'h00;
  localparam logic [7:0]  OFF_MASK      = 8'h04;
  localparam logic [7:0]  OFF_LEVEL     = 8'h08;
  localparam logic [7:0]  OFF_CAP_TMO   = 8'h0C;
  localparam logic [7:0]  OFF_COUNT     = 8'h10;

  // Status / mask layout
  localparam int unsigned NUM_CH        = 4;
  localparam int unsigned EV_W          = 6;
  localparam int unsigned EV_CH_LO      = 0;
  localparam int unsigned EV_RST_ASSERT = 4;
  localparam int unsigned EV_RST_RELEAS = 5;

  // Level register layout
  localparam int unsigned LV_SENSE_LO   = 0;
  localparam int unsigned LV_MCLR       = 4;
  localparam int unsigned LV_MARGIN     = 5;
  localparam int unsigned LV_BAND       = 6;
  localparam int unsigned LV_TSEL       = 7;
  localparam int unsigned LV_STATE_LO   = 8;
  localparam int unsigned LV_RESET      = 10;
  localparam int unsigned LV_W          = 11;

  // Synchroniser bit layout and idle values
  localparam int unsigned SY_W          = 8;
  localparam int unsigned SY_MCLR       = 4;
  localparam int unsigned SY_MARGIN     = 5;
  localparam int unsigned SY_BAND       = 6;
  localparam int unsigned SY_TSEL       = 7;
  // Sense rests above threshold so no flag pulses low after reset
  localparam logic [7:0]  SY_RST_VAL    = 8'hBF;

  // Reset values
  localparam logic [EV_W-1:0]  MASK_RST    = 6'h00;
  localparam logic [CNT_W-1:0] CAP_TMO_RST = CAP_TMO_CYC[CNT_W-1:0];

  typedef enum logic [1:0] {
    ST_HOLD    = 2'b00,
    ST_COUNT   = 2'b01,
    ST_RELEASE = 2'b10
  } mrs_state_t;
endpackage
`default_nettype wire

/* src/mrs_sync.sv */
`default_nettype none
module mrs_sync #(
  parameter int unsigned       W       = 8,
  parameter logic [W-1:0]      RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Data
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // mrs_sync
`default_nettype wire

/* src/mrs_supervisor.sv */
// Notes on behaviour
// RULE_01 - Margin low forces every output high; the code forces only the four flags and RESET_N, not IRQ
// RULE_02 - Channel flag follows its own sense input
// RULE_03 - Reset low on any fault or clear
// RULE_04 - Reset held one full timeout after clear
// RULE_05 - Band select strapped low 5%, high 10%
// RULE_06 - Manual clear active low, pulled up outside
// RULE_07 - Timeout pin high selects internal 140 ms
// RULE_08 - New fault during count restarts full timeout
`default_nettype none
module mrs_supervisor
  import mrs_pkg::*;
#(
  parameter int unsigned INT_TMO = INT_TMO_CYC
) (
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              SYS_RST,
  // Comparator results, high while above threshold
  input  wire logic              SENSE_INPUT_1,
  input  wire logic              SENSE_INPUT_2,
  input  wire logic              SENSE_INPUT_3,
  input  wire logic              SENSE_INPUT_4,
  // Straps and control pins
  input  wire logic              MANUAL_CLEAR_N,
  input  wire logic              MARGIN_N,
  input  wire logic              THRESHOLD_BAND_SELECT,
  input  wire logic              TIMEOUT_SELECT_PIN,
  // Supervisor outputs
  output var  logic              CHANNEL_FLAG_1_N,
  output var  logic              CHANNEL_FLAG_2_N,
  output var  logic              CHANNEL_FLAG_3_N,
  output var  logic              CHANNEL_FLAG_4_N,
  output var  logic              RESET_N,
  // Register port
  input  wire logic [ADDR_W-1:0] REG_ADDR,
  input  wire logic [DATA_W-1:0] REG_WDATA,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  output var  logic [DATA_W-1:0] REG_RDATA,
  // Interrupt
  output var  logic              IRQ
);

  if (INT_TMO < 1 || INT_TMO >= (1 << CNT_W)) begin : g_chk
    $error("INT_TMO must fit the timeout counter");
  end

  localparam logic [CNT_W-1:0] INT_LIMIT = INT_TMO[CNT_W-1:0];

  // Input synchronisation
  logic [SY_W-1:0] pins_s;

  mrs_sync #(
    .W       (SY_W),
    .RST_VAL (SY_RST_VAL)
  ) u_sync (
    .clk (CLK),
    .rst (SYS_RST),
    .d   ({TIMEOUT_SELECT_PIN, THRESHOLD_BAND_SELECT, MARGIN_N, MANUAL_CLEAR_N,
           SENSE_INPUT_4, SENSE_INPUT_3, SENSE_INPUT_2, SENSE_INPUT_1}),
    .q   (pins_s)
  );

  logic [NUM_CH-1:0] sense_ok;
  logic              mclr_n;
  logic              margin_n;
  logic              band_sel;
  logic              tsel;
  logic              fault;

  assign sense_ok = pins_s[NUM_CH-1:0];
  assign mclr_n   = pins_s[SY_MCLR];
  assign margin_n = pins_s[SY_MARGIN];
  assign band_sel = pins_s[SY_BAND];
  assign tsel     = pins_s[SY_TSEL];
  // Band only picks the analog thresholds; it is reported, not acted on
  assign fault    = ~(&sense_ok) | ~mclr_n; // RULE_03 RULE_06

  // Per-channel flags
  logic [NUM_CH-1:0] flag_q;
  logic [NUM_CH-1:0] sense_prev_q;

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        flag_q[i] <= 1'b1;
      end else begin
        flag_q[i] <= sense_ok[i] | ~margin_n; // RULE_02 RULE_01
      end
    end
  end

  assign CHANNEL_FLAG_1_N = flag_q[0];
  assign CHANNEL_FLAG_2_N = flag_q[1];
  assign CHANNEL_FLAG_3_N = flag_q[2];
  assign CHANNEL_FLAG_4_N = flag_q[3];

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sense_prev_q <= SY_RST_VAL[NUM_CH-1:0];
    end else begin
      sense_prev_q <= sense_ok;
    end
  end

  // Reset sequencer
  mrs_state_t       state_q;
  mrs_state_t       state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] limit;
  logic [CNT_W-1:0] cap_tmo_q;
  logic             reset_n_q;
  logic             cnt_done;

  // Capacitor timing is out of reach here; software sets its cycle count
  assign limit    = tsel ? INT_LIMIT : cap_tmo_q; // RULE_07
  // Compare with >= so a limit lowered mid-count cannot hang the sequencer
  assign cnt_done = (cnt_q + 24'h000001) >= limit;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    unique case (state_q)
      ST_HOLD: begin
        cnt_d = '0;
        if (!fault) begin
          state_d = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (fault) begin
          state_d = ST_HOLD; // RULE_08
          cnt_d   = '0;
        end else if (cnt_done) begin
          state_d = ST_RELEASE; // RULE_04
          cnt_d   = '0;
        end else begin
          cnt_d = cnt_q + 24'h000001;
        end
      end
      ST_RELEASE: begin
        if (fault) begin
          state_d = ST_HOLD; // RULE_03
        end
      end
      default: begin
        state_d = ST_HOLD;
        cnt_d   = '0;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_q <= ST_HOLD;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // Sequencer keeps running under margin so release timing stays honest
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      reset_n_q <= 1'b0;
    end else begin
      reset_n_q <= (state_d == ST_RELEASE) | ~margin_n; // RULE_04 RULE_01
    end
  end

  assign RESET_N = reset_n_q;

  // Register file
  logic [EV_W-1:0]   status_q;
  logic [EV_W-1:0]   mask_q;
  logic [EV_W-1:0]   events;
  logic [EV_W-1:0]   w1c;
  logic [DATA_W-1:0] rdata_q;
  logic              irq_q;
  logic [LV_W-1:0]   level;

  assign events[EV_CH_LO +: NUM_CH] = sense_prev_q & ~sense_ok;
  assign events[EV_RST_ASSERT]      = (state_q != ST_HOLD) && (state_d == ST_HOLD);
  assign events[EV_RST_RELEAS]      = (state_q == ST_COUNT) && (state_d == ST_RELEASE);
  assign w1c = (REG_WR && REG_ADDR == OFF_STATUS) ? REG_WDATA[EV_W-1:0] : '0;

  // Set beats clear so an event in the clearing cycle survives
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~w1c) | events;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mask_q    <= MASK_RST;
      cap_tmo_q <= CAP_TMO_RST;
    end else if (REG_WR) begin
      if (REG_ADDR == OFF_MASK) begin
        mask_q <= REG_WDATA[EV_W-1:0];
      end
      if (REG_ADDR == OFF_CAP_TMO) begin
        cap_tmo_q <= REG_WDATA[CNT_W-1:0];
      end
    end
  end

  assign level = {reset_n_q, state_q, tsel, band_sel, margin_n, mclr_n, sense_ok};

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rdata_q <= '0;
    end else if (REG_RD) begin
      unique case (REG_ADDR)
        OFF_STATUS:  rdata_q <= {{(DATA_W-EV_W){1'b0}}, status_q};
        OFF_MASK:    rdata_q <= {{(DATA_W-EV_W){1'b0}}, mask_q};
        OFF_LEVEL:   rdata_q <= {{(DATA_W-LV_W){1'b0}}, level};
        OFF_CAP_TMO: rdata_q <= {{(DATA_W-CNT_W){1'b0}}, cap_tmo_q};
        OFF_COUNT:   rdata_q <= {{(DATA_W-CNT_W){1'b0}}, cnt_q};
        default:     rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign REG_RDATA = rdata_q;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);
    end
  end

  assign IRQ = irq_q;

endmodule // mrs_supervisor
`default_nettype wire

/* dv/mrs_rails.sv */
`default_nettype none
module mrs_rails (
  // Bench commands
  input  wire logic [3:0] rail_ok,
  input  wire logic       clear_req,
  input  wire logic       band_10,
  // Pins toward the supervisor
  output var  logic [3:0] sense,
  output var  logic       clear_n,
  output var  logic       band
);
  timeunit 1ns;
  timeprecision 1ps;
  assign sense = rail_ok;
  // Open clear pin rests high through the pull-up
  assign clear_n = !clear_req;
  // Strap for the whole board, not per rail
  assign band = band_10;
endmodule // mrs_rails
`default_nettype wire

/* dv/mrs_supervisor_checker.sv */
`default_nettype none
module mrs_supervisor_checker
  import mrs_pkg::*;
#(
  parameter int unsigned INT_TMO = INT_TMO_CYC
) (
  // Clock and reset
  input wire logic              CLK,
  input wire logic              SYS_RST,
  // Pins
  input wire logic              MARGIN_N,
  input wire logic              MANUAL_CLEAR_N,
  input wire logic              TIMEOUT_SELECT_PIN,
  input wire logic              REG_RD,
  input wire logic              SENSE_INPUT_1,
  input wire logic              SENSE_INPUT_2,
  input wire logic              SENSE_INPUT_3,
  input wire logic              SENSE_INPUT_4,
  // Outputs
  input wire logic              CHANNEL_FLAG_1_N,
  input wire logic              CHANNEL_FLAG_2_N,
  input wire logic              CHANNEL_FLAG_3_N,
  input wire logic              CHANNEL_FLAG_4_N,
  input wire logic              RESET_N,
  input wire logic [DATA_W-1:0] REG_RDATA
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // Counted at the pins, so it runs ahead of the synchronised view
  logic [31:0] good_q;
  wire logic good = SENSE_INPUT_1 & SENSE_INPUT_2 & SENSE_INPUT_3 & SENSE_INPUT_4 & MANUAL_CLEAR_N;
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      good_q <= '0;
    end else begin
      good_q <= good ? good_q + 32'h1 : '0;
    end
  end
  chk_margin_all:
    assert property ((!MARGIN_N)[*4] |-> CHANNEL_FLAG_1_N && CHANNEL_FLAG_2_N && CHANNEL_FLAG_3_N
      && CHANNEL_FLAG_4_N && RESET_N) else $error("margin left an output low");
  chk_flag1_low:
    assert property ((MARGIN_N && !SENSE_INPUT_1)[*4] |-> !CHANNEL_FLAG_1_N) else $error("flag 1 high");
  chk_flag2_high:
    assert property ((MARGIN_N && SENSE_INPUT_2)[*4] |-> CHANNEL_FLAG_2_N) else $error("flag 2 low");
  chk_flag3_low:
    assert property ((MARGIN_N && !SENSE_INPUT_3)[*4] |-> !CHANNEL_FLAG_3_N) else $error("flag 3 high");
  chk_flag4_high:
    assert property ((MARGIN_N && SENSE_INPUT_4)[*4] |-> CHANNEL_FLAG_4_N) else $error("flag 4 low");
  chk_clear_reset:
    assert property ((MARGIN_N && !MANUAL_CLEAR_N)[*4] |-> !RESET_N) else $error("reset high on clear");
  chk_hold_full:
    assert property (MARGIN_N[*5] ##0 $rose(RESET_N) |-> good_q >= INT_TMO) else $error("early release");
  chk_release_due:
    assert property (TIMEOUT_SELECT_PIN && good_q > INT_TMO + 6 |-> RESET_N) else $error("late release");
  chk_rdata_idle:
    assert property (!$past(REG_RD) |-> REG_RDATA == '0) else $error("read data outside its cycle");
endmodule // mrs_supervisor_checker
bind mrs_supervisor mrs_supervisor_checker #(.INT_TMO(INT_TMO)) mrs_supervisor_checker_i (
  .CLK(CLK), .SYS_RST(SYS_RST), .MARGIN_N(MARGIN_N), .MANUAL_CLEAR_N(MANUAL_CLEAR_N),
  .TIMEOUT_SELECT_PIN(TIMEOUT_SELECT_PIN), .REG_RD(REG_RD), .SENSE_INPUT_1(SENSE_INPUT_1),
  .SENSE_INPUT_2(SENSE_INPUT_2), .SENSE_INPUT_3(SENSE_INPUT_3), .SENSE_INPUT_4(SENSE_INPUT_4),
  .CHANNEL_FLAG_1_N(CHANNEL_FLAG_1_N), .CHANNEL_FLAG_2_N(CHANNEL_FLAG_2_N), .CHANNEL_FLAG_3_N(CHANNEL_FLAG_3_N),
  .CHANNEL_FLAG_4_N(CHANNEL_FLAG_4_N), .RESET_N(RESET_N), .REG_RDATA(REG_RDATA));
`default_nettype wire

/* dv/tb_mrs_supervisor.sv */
`default_nettype none
module tb_mrs_supervisor
  import mrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TMO = 20;
  logic clk = 1'b0, rst = 1'b1, clr = 1'b0, band = 1'b0, margin_n = 1'b1, wr = 1'b0, rd = 1'b0;
  logic        tsel = 1'b1;
  logic [3:0]  ok = 4'hF;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  sense, flags;
  logic        clr_n, band_pin, rst_n, irq;
  int          n_errors = 0, compares = 0;
  always #25 clk = ~clk;
  mrs_rails rails_i (.rail_ok(ok), .clear_req(clr), .band_10(band), .sense(sense), .clear_n(clr_n), .band(band_pin));
  mrs_supervisor #(.INT_TMO(TMO)) mrs_supervisor_i (
    .CLK(clk), .SYS_RST(rst), .SENSE_INPUT_1(sense[0]), .SENSE_INPUT_2(sense[1]), .SENSE_INPUT_3(sense[2]),
    .SENSE_INPUT_4(sense[3]), .MANUAL_CLEAR_N(clr_n), .MARGIN_N(margin_n), .THRESHOLD_BAND_SELECT(band_pin),
    .TIMEOUT_SELECT_PIN(tsel), .CHANNEL_FLAG_1_N(flags[0]), .CHANNEL_FLAG_2_N(flags[1]),
    .CHANNEL_FLAG_3_N(flags[2]), .CHANNEL_FLAG_4_N(flags[3]), .RESET_N(rst_n), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .IRQ(irq));
  task automatic end_of_test();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic expect_eq(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      $display("MISMATCH %0t %s", $time, what);
      n_errors++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 expect_eq(rdata, exp, what);
  endtask
  // Holds off until release and checks the hold against the limit, allowing for the synchroniser
  task automatic wait_rel(input int lim = TMO);
    int n = 0;
    while (rst_n !== 1'b1 && n < 200) @(posedge clk) #1 n++;
    if (rst_n !== 1'b1) begin
      $display("MISMATCH %0t reset never released", $time);
      n_errors++;
      end_of_test();
    end
    expect_eq({31'h0, n >= lim && n <= lim + 6}, 32'h1, "hold length");
  endtask
  task automatic t_flags();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      ok <= 4'hF & ~(4'h1 << i);
      cyc(4);
      expect_eq({28'h0, flags}, {28'h0, 4'hF & ~(4'h1 << i)}, "flag pattern");
      expect_eq({31'h0, rst_n}, 32'h0, "reset on rail fault");
      @(posedge clk);
      ok <= 4'hF;
      wait_rel();
    end
    $display("t_flags done");
  endtask
  task automatic t_restart();
    @(posedge clk);
    ok <= 4'hB;
    cyc(4);
    @(posedge clk);
    ok <= 4'hF;
    cyc(TMO / 2);
    @(posedge clk);
    ok <= 4'hB;
    cyc(2);
    @(posedge clk);
    ok <= 4'hF;
    wait_rel();
    $display("t_restart done");
  endtask
  task automatic t_clear_margin();
    @(posedge clk);
    clr <= 1'b1;
    cyc(4);
    expect_eq({27'h0, rst_n, flags}, 32'h0F, "reset on clear");
    @(posedge clk);
    ok <= 4'h0;
    margin_n <= 1'b0;
    cyc(4);
    expect_eq({27'h0, rst_n, flags}, 32'h1F, "margin override");
    @(posedge clk);
    margin_n <= 1'b1;
    cyc(4);
    expect_eq({27'h0, rst_n, flags}, 32'h00, "margin removed");
    @(posedge clk);
    ok <= 4'hF;
    clr <= 1'b0;
    wait_rel();
    $display("t_clear_margin done");
  endtask
  task automatic t_regs();
    reg_rd(OFF_MASK, 32'h0, "mask reset");
    reg_rd(OFF_CAP_TMO, 32'h000003E8, "cap timeout reset");
    reg_rd(OFF_LEVEL, 32'h000006BF, "level 5 pct");
    @(posedge clk);
    band <= 1'b1;
    cyc(4);
    reg_rd(OFF_LEVEL, 32'h000006FF, "level 10 pct");
    reg_rd(8'h20, 32'h0, "unmapped read");
    reg_wr(OFF_MASK, 32'h1);
    reg_wr(OFF_STATUS, 32'h3F);
    cyc(2);
    expect_eq({31'h0, irq}, 32'h0, "irq after clear");
    @(posedge clk);
    ok <= 4'hE;
    cyc(6);
    expect_eq({31'h0, irq}, 32'h1, "irq on rail fall");
    reg_wr(OFF_STATUS, 32'h1);
    cyc(2);
    expect_eq({31'h0, irq}, 32'h0, "masked event raised irq");
    @(posedge clk);
    ok <= 4'hF;
    wait_rel();
    $display("t_regs done");
  endtask
  // Strap low hands the limit to the software count, longer than the internal one
  task automatic t_cap_timeout();
    @(posedge clk);
    tsel <= 1'b0;
    reg_wr(OFF_CAP_TMO, 32'h00000028);
    reg_rd(OFF_CAP_TMO, 32'h00000028, "cap timeout write");
    @(posedge clk);
    ok <= 4'h7;
    cyc(4);
    expect_eq({28'h0, flags}, 32'h00000007, "flag 4 low");
    expect_eq({31'h0, rst_n}, 32'h0, "reset on rail 4");
    @(posedge clk);
    ok <= 4'hF;
    cyc(4);
    reg_rd(OFF_COUNT, 32'h00000002, "count running");
    // Six edges of the hold already spent before the wait starts
    wait_rel(40 - 6);
    $display("t_cap_timeout done");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wait_rel();
    t_flags();
    t_restart();
    t_clear_margin();
    t_regs();
    t_cap_timeout();
    end_of_test();
  end
endmodule // tb_mrs_supervisor
`default_nettype wire
